// ==== acmp_ctrl.sv ====
// comparator control: input selection, result, interrupt and registers
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "acmp_regs.svh"
module acmp_ctrl
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic comparator_raw,
	input wire logic converter_enable,
	input wire logic converter_power_reduce,
	input wire logic [2:0] channel_select_field,
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	input wire logic positive_input_pin,
	input wire logic negative_input_pin,
	output logic comparator_power_off,
	output logic positive_from_bandgap,
	output logic negative_from_channel,
	output logic [2:0] negative_channel,
	output logic comparator_result,
	output logic comparator_irq_request,
	output logic capture_input,
	output logic positive_pin_buffer_off,
	output logic negative_pin_buffer_off,
	output logic positive_pin_value,
	output logic negative_pin_value,
	output logic irq
);

	// control and status fields
	logic disable_reg;
	logic bandgap_reg;
	logic flag_reg;
	logic irq_enable_reg;
	logic capture_reg;
	logic [1:0] mode_reg;
	logic [7:0] ccb_reg;
	logic [1:0] pid_reg;
	logic [`ACMP_IST_WIDTH-1:0] ist_reg;
	logic [`ACMP_IST_WIDTH-1:0] ien_reg;
	logic [7:0] rdata_reg;
	logic pos_pin_reg;
	logic neg_pin_reg;
	logic capture_reg_out;

	// next values
	logic flag_next;
	logic [`ACMP_IST_WIDTH-1:0] ist_next;
	logic [7:0] rdata_next;

	// address decode
	wire sel_csr = (addr == `ACMP_ADDR_CSR);
	wire sel_ccb = (addr == `ACMP_ADDR_CCB);
	wire sel_pid = (addr == `ACMP_ADDR_PID);
	wire sel_ist = (addr == `ACMP_ADDR_IST);
	wire sel_icl = (addr == `ACMP_ADDR_ICL);
	wire sel_ien = (addr == `ACMP_ADDR_IEN);

	wire wr_csr = wr & sel_csr;
	wire wr_ccb = wr & sel_ccb;
	wire wr_pid = wr & sel_pid;
	wire wr_icl = wr & sel_icl;
	wire wr_ien = wr & sel_ien;

	// result path
	wire raw_gated;
	wire result_sync;
	wire mode_event;
	wire toggle_event;
	acmp_pkg::acmp_mode_type mode_cast;
	acmp_pkg::acmp_neg_src_type neg_src;

	// a powered-down comparator gives a defined low level
	assign raw_gated = comparator_raw & ~disable_reg;

	acmp_sync u_sync
	(
		.clock(clock),
		.rstn(rstn),
		.async_in(raw_gated),
		.sync_out(result_sync)
	);

	assign mode_cast = acmp_pkg::acmp_mode_type'(mode_reg);

	acmp_edge u_edge
	(
		.clock(clock),
		.rstn(rstn),
		.level(result_sync),
		.mode(mode_cast),
		.mode_event(mode_event),
		.toggle_event(toggle_event)
	);

	// result is high when the positive input is above the negative one
	assign comparator_result = result_sync;

	// negative input selection
	wire mux_enable = ccb_reg[`ACMP_CCB_MUX_EN];
	wire mux_usable = mux_enable & ~converter_enable
		& ~converter_power_reduce;

	assign neg_src = mux_usable ? acmp_pkg::ACMP_NEG_CHANNEL
		: acmp_pkg::ACMP_NEG_PIN;
	assign negative_from_channel = (neg_src == acmp_pkg::ACMP_NEG_CHANNEL);
	// channel code is passed only while the channel path is chosen
	assign negative_channel = mux_usable ? channel_select_field
		: 3'h0;

	// positive input selection
	assign positive_from_bandgap = bandgap_reg;
	assign comparator_power_off = disable_reg;

	// interrupt flag: hardware set wins over any clear
	wire flag_clear_sw = wr_csr & wdata[`ACMP_CSR_FLAG];
	wire flag_clear = flag_clear_sw | irq_vector_taken;

	always_comb
	begin
		flag_next = flag_reg;
		if (flag_clear)
			flag_next = 1'b0;
		if (mode_event)
			flag_next = 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;
	end

	assign comparator_irq_request = flag_reg & irq_enable_reg
		& global_irq_enable;

	// control and status register, writable fields
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			disable_reg <= 1'b0;
			bandgap_reg <= 1'b0;
			irq_enable_reg <= 1'b0;
			capture_reg <= 1'b0;
			mode_reg <= 2'h0;
		end
		else if (wr_csr)
		begin
			disable_reg <= wdata[`ACMP_CSR_DISABLE];
			bandgap_reg <= wdata[`ACMP_CSR_BANDGAP];
			irq_enable_reg <= wdata[`ACMP_CSR_IRQ_EN];
			capture_reg <= wdata[`ACMP_CSR_CAPTURE];
			mode_reg <= wdata[`ACMP_CSR_MODE_HI:`ACMP_CSR_MODE_LO];
		end
	end

	// converter control b: only the mux enable steers this block
	always_ff @(posedge clock)
	begin
		if (!rstn)
			ccb_reg <= `ACMP_CCB_RESET;
		else if (wr_ccb)
			ccb_reg <= wdata;
	end

	// pin input disable
	always_ff @(posedge clock)
	begin
		if (!rstn)
			pid_reg <= `ACMP_PID_RESET;
		else if (wr_pid)
			pid_reg <= wdata[1:0];
	end

	assign positive_pin_buffer_off = pid_reg[`ACMP_PID_POS_OFF];
	assign negative_pin_buffer_off = pid_reg[`ACMP_PID_NEG_OFF];

	// port input values forced low while the buffer is off
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			pos_pin_reg <= 1'b0;
			neg_pin_reg <= 1'b0;
		end
		else
		begin
			pos_pin_reg <= positive_input_pin
				& ~pid_reg[`ACMP_PID_POS_OFF];
			neg_pin_reg <= negative_input_pin
				& ~pid_reg[`ACMP_PID_NEG_OFF];
		end
	end

	assign positive_pin_value = pos_pin_reg;
	assign negative_pin_value = neg_pin_reg;

	// capture routing; zero when the route is off
	always_ff @(posedge clock)
	begin
		if (!rstn)
			capture_reg_out <= 1'b0;
		else
			capture_reg_out <= capture_reg & result_sync;
	end

	assign capture_input = capture_reg_out;

	// sticky event status, clear by writing one, set wins
	wire [`ACMP_IST_WIDTH-1:0] ist_set = {toggle_event, mode_event};
	wire [`ACMP_IST_WIDTH-1:0] ist_clr = wr_icl ?
		wdata[`ACMP_IST_WIDTH-1:0] : `ACMP_IRQ_RESET;

	assign ist_next = (ist_reg & ~ist_clr) | ist_set;

	always_ff @(posedge clock)
	begin
		if (!rstn)
			ist_reg <= `ACMP_IRQ_RESET;
		else
			ist_reg <= ist_next;
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			ien_reg <= `ACMP_IRQ_RESET;
		else if (wr_ien)
			ien_reg <= wdata[`ACMP_IST_WIDTH-1:0];
	end

	assign irq = |(ist_reg & ien_reg);

	// read data
	wire [7:0] csr_value = {disable_reg, bandgap_reg, result_sync,
		flag_reg, irq_enable_reg, capture_reg, mode_reg};
	wire [7:0] pid_value = {6'h00, pid_reg};
	wire [7:0] ist_value = {6'h00, ist_reg};
	wire [7:0] ien_value = {6'h00, ien_reg};

	always_comb
	begin
		rdata_next = 8'h00;
		if (rd)
		begin
			case (1'b1)
			sel_csr:
				rdata_next = csr_value;
			sel_ccb:
				rdata_next = ccb_reg;
			sel_pid:
				rdata_next = pid_value;
			sel_ist:
				rdata_next = ist_value;
			sel_ien:
				rdata_next = ien_value;
			default:
				rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	assign rdata = rdata_reg;

endmodule

// ==== acmp_ctrl_checker.sv ====
// port assertions of the comparator control block
`timescale 1ns/100ps
`include "acmp_regs.svh"
module acmp_chk
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic comparator_raw,
	input wire logic converter_enable,
	input wire logic converter_power_reduce,
	input wire logic [2:0] channel_select_field,
	input wire logic global_irq_enable,
	input wire logic comparator_power_off,
	input wire logic positive_from_bandgap,
	input wire logic negative_from_channel,
	input wire logic [2:0] negative_channel,
	input wire logic comparator_result,
	input wire logic comparator_irq_request,
	input wire logic positive_pin_buffer_off,
	input wire logic positive_pin_value
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	AST_SYNC: assert property (
		$past(rstn, 3) && !comparator_power_off && !$past(comparator_power_off, 2)
		|-> comparator_result == $past(comparator_raw, 2))
		else $error("result lag wrong");
	AST_MUX_CH: assert property (negative_from_channel |->
		!converter_enable && negative_channel == channel_select_field)
		else $error("channel source wrong");
	AST_MUX_PIN: assert property (
		converter_enable || converter_power_reduce
		|-> !negative_from_channel && negative_channel == 3'h0)
		else $error("pin source wrong");
	AST_CSR_WR: assert property (wr && addr == `ACMP_ADDR_CSR |=>
		{comparator_power_off, positive_from_bandgap} == $past(wdata[7:6]))
		else $error("control bits wrong");
	AST_REQ: assert property (!global_irq_enable |->
		!comparator_irq_request)
		else $error("request without global enable");
	AST_FLAG: assert property (
		$rose(comparator_irq_request) && !$past(wr) && $stable(global_irq_enable)
		|-> $past(comparator_result) != $past(comparator_result, 2))
		else $error("flag without edge");
	AST_PID: assert property (
		$past(rd) && $past(addr) == `ACMP_ADDR_PID |-> rdata[7:2] == 6'h00)
		else $error("unused bits set");
	AST_PIN_OFF: assert property (
		positive_pin_buffer_off && $past(positive_pin_buffer_off)
		|-> !positive_pin_value)
		else $error("pin reads high");
endmodule
bind acmp_ctrl acmp_chk u_chk (.*);

// ==== acmp_edge.sv ====
// edge detector on the synchronised result, qualified by interrupt mode
`timescale 1ns/100ps
module acmp_edge
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic level,
	input wire acmp_pkg::acmp_mode_type mode,
	output logic mode_event,
	output logic toggle_event
);

	logic prev_reg;
	logic rise;
	logic fall;

	always_ff @(posedge clock)
	begin
		if (!rstn)
			prev_reg <= 1'b0;
		else
			prev_reg <= level;
	end

	assign rise = level & ~prev_reg;
	assign fall = ~level & prev_reg;
	assign toggle_event = rise | fall;

	always_comb
	begin
		case (mode)
		acmp_pkg::ACMP_MODE_TOGGLE:
			mode_event = toggle_event;
		acmp_pkg::ACMP_MODE_FALL:
			mode_event = fall;
		acmp_pkg::ACMP_MODE_RISE:
			mode_event = rise;
		default:
			mode_event = 1'b0;
		endcase
	end

endmodule

// ==== acmp_front.sv ====
// behavioural comparator front end with selectable inputs
`timescale 1ns/100ps
module acmp_front
(
	input wire logic clock,
	input wire logic comparator_power_off,
	input wire logic positive_from_bandgap,
	input wire logic negative_from_channel,
	input wire logic [2:0] negative_channel,
	input wire logic [7:0] pos_lv,
	input wire logic [7:0] neg_lv,
	input wire logic [63:0] ch_lv,
	output logic comparator_raw
);
	localparam logic [7:0] BANDGAP_LV = 8'h10;
	logic [7:0] p;
	logic [7:0] n;
	logic wander = 1'b0;
	assign p = positive_from_bandgap ? BANDGAP_LV : pos_lv;
	assign n = negative_from_channel ? ch_lv[{negative_channel, 3'h0}+:8]
		: neg_lv;
	// unpowered output wanders
	always @(posedge clock)
		wander <= ~wander;
	assign comparator_raw = comparator_power_off ? wander : p > n;
endmodule

// ==== acmp_pkg.sv ====
// types shared by the comparator control block
package acmp_pkg;

	typedef enum logic [1:0] {
		ACMP_MODE_TOGGLE = 2'h0,
		ACMP_MODE_RESERVED = 2'h1,
		ACMP_MODE_FALL = 2'h2,
		ACMP_MODE_RISE = 2'h3
	} acmp_mode_type;

	typedef enum logic [1:0] {
		ACMP_NEG_PIN = 2'h0,
		ACMP_NEG_CHANNEL = 2'h1
	} acmp_neg_src_type;

endpackage

// ==== acmp_regs.svh ====
// register offsets, field positions and reset values of the comparator block
// Functional notes
// - result is one when positive input exceeds negative input, else zero
// - raw comparator output is synchronised, one to two clocks of latency
// - mux enabled and converter off: channel field picks channel 0 to 7
// - mux disabled or converter on: negative input is the dedicated pin
// - bandgap select picks bandgap for positive input, else positive pin
// - disable bit powers the comparator off, writable at any time
// - mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge
// - flag is set when synchronised output shows the selected event
// - flag clears on vector execution or on a write of one
// - request while flag, enable and global enable are all one
// - capture enable routes the result to the timer capture front end
// - buffer-off bit turns pin buffer off and its port bit reads zero
// - bits 7 to 2 of the pin input disable register read zero
// - converter mux usable as negative source only with power reduce low
// - converter enable bit is observed by the negative mux selection
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH

`define ACMP_ADDR_CSR 8'h30
`define ACMP_ADDR_CCB 8'h34
`define ACMP_ADDR_PID 8'h38
`define ACMP_ADDR_IST 8'h3C
`define ACMP_ADDR_ICL 8'h40
`define ACMP_ADDR_IEN 8'h44

`define ACMP_CSR_DISABLE 7
`define ACMP_CSR_BANDGAP 6
`define ACMP_CSR_RESULT 5
`define ACMP_CSR_FLAG 4
`define ACMP_CSR_IRQ_EN 3
`define ACMP_CSR_CAPTURE 2
`define ACMP_CSR_MODE_HI 1
`define ACMP_CSR_MODE_LO 0

`define ACMP_CCB_MUX_EN 6

`define ACMP_PID_NEG_OFF 1
`define ACMP_PID_POS_OFF 0

`define ACMP_IST_EVENT 0
`define ACMP_IST_TOGGLE 1
`define ACMP_IST_WIDTH 2

`define ACMP_CSR_RESET 8'h00
`define ACMP_CCB_RESET 8'h00
`define ACMP_PID_RESET 2'h0
`define ACMP_IRQ_RESET 2'h0

`endif

// ==== acmp_sync.sv ====
// two-stage synchroniser for the raw comparator output
`timescale 1ns/100ps
module acmp_sync
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic async_in,
	output logic sync_out
);

	logic stage1_reg;
	logic stage2_reg;

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end
		else
		begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;

endmodule

// ==== test_analog_comparator_control.sv ====
// self-checking bench of the comparator control block
`timescale 1ns/100ps
`include "acmp_regs.svh"
module test_analog_comparator_control;
	logic clock, rstn = 0, wr = 0, rd = 0, irq_vector_taken = 0;
	logic converter_enable = 0, converter_power_reduce = 0;
	logic global_irq_enable = 1, positive_input_pin = 1, negative_input_pin = 1;
	logic [7:0] addr = 0, wdata = 0, rdata, pos_lv = 0, neg_lv = 8'h40;
	logic [2:0] channel_select_field = 0, negative_channel;
	logic [63:0] ch_lv = 64'hE0C0A08060402000;
	logic comparator_raw, comparator_power_off, positive_from_bandgap;
	logic negative_from_channel, comparator_result, comparator_irq_request;
	logic capture_input, positive_pin_buffer_off, negative_pin_buffer_off;
	logic positive_pin_value, negative_pin_value, irq;
	int num_errors, cmp_count, cyc;
	acmp_ctrl u_dut (.*);
	acmp_front u_front (.*);
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			num_errors++;
			summarize();
		end
	end
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		w(1);
		wr <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		w(1);
		rd <= 1'b0;
		chk(rdata & m, e);
	endtask
	task t_regs;
		rdc(`ACMP_ADDR_CSR, 8'hFF, `ACMP_CSR_RESET);
		rdc(`ACMP_ADDR_CCB, 8'hFF, `ACMP_CCB_RESET);
		rdc(8'h50, 8'hFF, 8'h00);
		wrr(`ACMP_ADDR_PID, 8'hFF);
		w(2);
		chk(8'({positive_pin_value, negative_pin_value}), 8'h00);
		chk(8'({positive_pin_buffer_off, negative_pin_buffer_off}), 8'h03);
		rdc(`ACMP_ADDR_PID, 8'hFF, 8'h03);
		wrr(`ACMP_ADDR_PID, 8'h00);
		w(2);
		chk(8'({positive_pin_value, negative_pin_value}), 8'h03);
		$display("registers done");
	endtask
	task t_sel;
		pos_lv <= 8'h80;
		wrr(`ACMP_ADDR_CCB, 8'h40);
		for (int k = 0; k < 8; k++)
		begin
			channel_select_field <= 3'(k);
			w(3);
			chk(8'(negative_channel), 8'(k));
			chk(8'(comparator_result), k < 4 ? 8'h01 : 8'h00);
			rdc(`ACMP_ADDR_CSR, 8'h20, k < 4 ? 8'h20 : 8'h00);
		end
		for (int k = 0; k < 2; k++)
		begin
			converter_enable <= k == 0;
			converter_power_reduce <= k == 1;
			w(3);
			chk(8'(negative_from_channel), 8'h00);
			rdc(`ACMP_ADDR_CSR, 8'h20, 8'h20);
		end
		converter_power_reduce <= 1'b0;
		channel_select_field <= 3'h1;
		wrr(`ACMP_ADDR_CSR, 8'h40);
		w(3);
		rdc(`ACMP_ADDR_CSR, 8'h60, 8'h40);
		channel_select_field <= 3'h0;
		wrr(`ACMP_ADDR_CSR, 8'h80);
		w(4);
		rdc(`ACMP_ADDR_CSR, 8'hA0, 8'h80);
		wrr(`ACMP_ADDR_CSR, 8'h04);
		w(4);
		chk(8'(capture_input), 8'h01);
		wrr(`ACMP_ADDR_CSR, 8'h00);
		w(2);
		chk(8'(capture_input), 8'h00);
		$display("selection done");
	endtask
	task t_irq;
		logic [7:0] r, f;
		pos_lv <= 8'h00;
		w(4);
		for (int m = 0; m < 4; m++)
		begin
			r = (m == 0 || m == 3) ? 8'h10 : 8'h00;
			f = (m == 0 || m == 2) ? 8'h10 : 8'h00;
			wrr(`ACMP_ADDR_CSR, 8'(m) | 8'h10);
			wrr(`ACMP_ADDR_ICL, 8'h03);
			pos_lv <= 8'h80;
			w(4);
			rdc(`ACMP_ADDR_CSR, 8'h10, r);
			rdc(`ACMP_ADDR_IST, 8'h03, (r >> 4) | 8'h02);
			wrr(`ACMP_ADDR_IEN, 8'h01);
			chk(8'(irq), r >> 4);
			wrr(`ACMP_ADDR_IEN, 8'h00);
			chk(8'(irq), 8'h00);
			wrr(`ACMP_ADDR_CSR, 8'(m) | 8'h08);
			chk(8'(comparator_irq_request), r >> 4);
			global_irq_enable <= 1'b0;
			w(1);
			chk(8'(comparator_irq_request), 8'h00);
			global_irq_enable <= 1'b1;
			irq_vector_taken <= 1'b1;
			w(1);
			irq_vector_taken <= 1'b0;
			w(1);
			chk(8'(comparator_irq_request), 8'h00);
			pos_lv <= 8'h00;
			w(4);
			chk(8'(comparator_irq_request), f >> 4);
			wrr(`ACMP_ADDR_CSR, 8'(m));
			rdc(`ACMP_ADDR_CSR, 8'h10, f);
			wrr(`ACMP_ADDR_CSR, 8'(m) | 8'h10);
			rdc(`ACMP_ADDR_CSR, 8'h10, 8'h00);
		end
		$display("interrupts done");
	endtask
	initial
	begin
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		t_regs();
		t_sel();
		t_irq();
		summarize();
	end
endmodule
